//--- rtl/timer_capture_compare_pwm.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module timer_capture_compare_pwm (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_external_count_clock,
  input  wire logic [3:0] i_channel_pin,
  output logic      [3:0] o_channel_pin,
  output logic      [3:0] o_channel_pin_oe,
  output logic            o_wrap_irq,
  output logic      [3:0] o_channel_irq,
  output logic      [3:0] o_channel_dma_req
);
  import timer_pkg::*;

  state_t state_reg;
  state_t state_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        tick;
    logic        wrap;
    logic [5:0]  mask;
    logic [15:0] cnt_inc;
    logic [7:0]  a_sc;
    logic [7:0]  a_hi;
    logic [7:0]  a_lo;
    logic        paired;
    logic        cap_mode;
    logic        cmp_mode;
    logic        edge_hit;
    logic        match;
    logic        ev;
    logic [15:0] cmp_val;
    logic        rise;
    logic        fall;
    tick = 1'b0;
    wrap = 1'b0;
    mask = 6'h00;
    cnt_inc = 16'h0000;
    a_sc = 8'h00;
    a_hi = 8'h00;
    a_lo = 8'h00;
    paired = 1'b0;
    cap_mode = 1'b0;
    cmp_mode = 1'b0;
    edge_hit = 1'b0;
    match = 1'b0;
    ev = 1'b0;
    cmp_val = 16'h0000;
    rise = 1'b0;
    fall = 1'b0;
    state_next = state_reg;
    state_next.rd_data = 8'h00;

    // Two-flop synchronisers for everything arriving from pins
    state_next.ext_s1 = i_external_count_clock;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.ext_prev = state_reg.ext_s2;
    state_next.pin_s1 = i_channel_pin;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_prev = state_reg.pin_s2;

    // ****************************************
    // Count clock and counter
    // ****************************************
    mask = 6'((7'h01 << state_reg.psel) - 7'h01);
    if (!state_reg.halt) begin  // [R24]
      state_next.presc = 6'(state_reg.presc + 6'h01);
      if (state_reg.psel == `TIM_PSEL_EXT) begin  // [R2]
        tick = state_reg.ext_s2 & ~state_reg.ext_prev;
      end else begin
        tick = (state_reg.presc & mask) == mask;  // [R2]
      end
    end
    cnt_inc = state_reg.cnt + 16'h0001;
    if (tick) begin
      if (state_reg.cnt == state_reg.modv) begin  // [R5]
        wrap = 1'b1;
        state_next.cnt = 16'h0000;
        // Modulo half-written: a wrap here would use a torn value
        if (!state_reg.mod_pending) begin  // [R6]
          state_next.wrap_flag = 1'b1;
          state_next.wrap_armed = 1'b0;  // [R5]
        end
      end else begin
        state_next.cnt = cnt_inc;
      end
    end

    // ****************************************
    // Global registers
    // ****************************************
    if (i_rd) begin
      unique case (i_addr)
        `TIM_A_CTL: begin
          state_next.rd_data = {state_reg.wrap_flag, state_reg.wrap_ie, state_reg.halt,
                                2'b00, state_reg.psel};  // [R23]
          state_next.wrap_armed = state_reg.wrap_flag;
        end
        `TIM_A_CNT_HI: begin
          state_next.rd_data = state_reg.cnt[15:8];  // [R25]
          if (!state_reg.cnt_latched) begin  // [R3]
            state_next.lo_latch = state_reg.cnt[7:0];
            state_next.cnt_latched = 1'b1;
          end
        end
        `TIM_A_CNT_LO: begin
          state_next.rd_data = state_reg.cnt_latched ? state_reg.lo_latch
                                                     : state_reg.cnt[7:0];  // [R3]
          state_next.cnt_latched = 1'b0;
        end
        `TIM_A_MOD_HI: state_next.rd_data = state_reg.modv[15:8];
        `TIM_A_MOD_LO: state_next.rd_data = state_reg.modv[7:0];
        `TIM_A_DMA:    state_next.rd_data = {4'h0, state_reg.dma};
        default: ;
      endcase
    end
    if (i_wr) begin
      unique case (i_addr)
        `TIM_A_CTL: begin
          state_next.wrap_ie = i_wr_data[`TIM_B_IE];
          state_next.halt = i_wr_data[`TIM_B_HALT];  // [R24]
          state_next.psel = i_wr_data[2:0];  // [R2]
          // A wrap landing in the clearing write keeps the flag set
          if (!i_wr_data[`TIM_B_FLAG] && state_reg.wrap_armed &&
              !(wrap && !state_reg.mod_pending)) begin
            state_next.wrap_flag = 1'b0;
          end
          state_next.wrap_armed = 1'b0;
          if (i_wr_data[`TIM_B_RST]) begin  // [R23]
            state_next.cnt = 16'h0000;  // [R1] [R4]
            state_next.presc = 6'h00;
          end
        end
        `TIM_A_MOD_HI: begin
          state_next.modv[15:8] = i_wr_data;
          state_next.mod_pending = 1'b1;  // [R6]
        end
        `TIM_A_MOD_LO: begin
          state_next.modv[7:0] = i_wr_data;
          state_next.mod_pending = 1'b0;  // [R6]
        end
        `TIM_A_DMA: state_next.dma = i_wr_data[3:0];  // [R11]
        default: ;
      endcase
    end

    // ****************************************
    // Channels
    // ****************************************
    for (int i = 0; i < 4; i++) begin
      a_sc = 8'(`TIM_A_CH_BASE + `TIM_A_CH_STEP * i);
      a_hi = 8'(a_sc + 8'h01);
      a_lo = 8'(a_sc + 8'h02);
      // Odd channel is swallowed by its even partner in buffered mode
      paired = (i % 2 == 1) && state_reg.ch[i - (i % 2)].msb;  // [R14]
      cap_mode = !state_reg.ch[i].msb && !state_reg.ch[i].msa &&
                 {state_reg.ch[i].elsb, state_reg.ch[i].elsa} != 2'b00;  // [R15]
      cmp_mode = (state_reg.ch[i].msb || state_reg.ch[i].msa) &&
                 {state_reg.ch[i].elsb, state_reg.ch[i].elsa} != 2'b00;  // [R15]
      rise = state_reg.pin_s2[i] & ~state_reg.pin_prev[i];
      fall = ~state_reg.pin_s2[i] & state_reg.pin_prev[i];
      unique case ({state_reg.ch[i].elsb, state_reg.ch[i].elsa})  // [R16]
        2'b01:   edge_hit = rise;
        2'b10:   edge_hit = fall;
        2'b11:   edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
      cmp_val = state_reg.ch[i].val;
      if (state_reg.ch[i].msb) begin
        cmp_val = state_reg.pair_act[i / 2] ? state_reg.ch[i | 1].val : state_reg.ch[i].val;
      end
      match = tick && cmp_mode && !state_reg.ch[i].hold_wr &&
              state_next.cnt == cmp_val;  // [R22]

      // Bus accesses to this channel
      if (i_rd && !paired) begin
        if (i_addr == a_sc) begin
          state_next.rd_data = {state_reg.ch[i].flag, state_reg.ch[i].ie,
                                state_reg.ch[i].msb, state_reg.ch[i].msa,
                                state_reg.ch[i].elsb, state_reg.ch[i].elsa,
                                state_reg.ch[i].tov, state_reg.ch[i].max};
          state_next.ch[i].armed = state_reg.ch[i].flag;  // [R9]
        end
        if (i_addr == a_hi) begin
          state_next.rd_data = state_reg.ch[i].val[15:8];
          state_next.ch[i].hold_rd = 1'b1;  // [R13] [R20] [R22]
        end
        if (i_addr == a_lo) begin
          state_next.rd_data = state_reg.ch[i].val[7:0];
          state_next.ch[i].hold_rd = 1'b0;
        end
      end
      if (i_wr && i_addr == a_sc && !paired) begin  // [R14]
        state_next.ch[i].ie = i_wr_data[`TIM_B_IE];  // [R11]
        state_next.ch[i].msb = (i % 2 == 0) ? i_wr_data[`TIM_B_MSB] : 1'b0;  // [R14]
        state_next.ch[i].msa = i_wr_data[`TIM_B_MSA];
        state_next.ch[i].elsb = i_wr_data[`TIM_B_ELSB];
        state_next.ch[i].elsa = i_wr_data[`TIM_B_ELSA];
        state_next.ch[i].tov = i_wr_data[`TIM_B_TOV];
        state_next.ch[i].max = i_wr_data[`TIM_B_MAX];
        if (!i_wr_data[`TIM_B_FLAG] && state_reg.ch[i].armed) begin  // [R9]
          state_next.ch[i].flag = 1'b0;
        end
        state_next.ch[i].armed = 1'b0;
      end
      if (i_wr && i_addr == a_hi) begin
        state_next.ch[i].val[15:8] = i_wr_data;  // [R25]
        state_next.ch[i].hold_wr = 1'b1;  // [R22]
      end
      if (i_wr && i_addr == a_lo) begin
        state_next.ch[i].val[7:0] = i_wr_data;
        state_next.ch[i].hold_wr = 1'b0;  // [R22]
        state_next.pair_last[i / 2] = (i % 2 == 1);
      end
      // DMA routing clears on any low value access
      if ((i_rd || i_wr) && i_addr == a_lo && state_reg.ch[i].ie && state_reg.dma[i]) begin
        state_next.ch[i].flag = 1'b0;  // [R10]
      end

      // Capture and compare events; set wins over every clear above
      ev = 1'b0;
      if (!paired && cap_mode && edge_hit && !state_reg.ch[i].hold_rd) begin  // [R22]
        state_next.ch[i].val = state_reg.cnt;
        ev = 1'b1;
      end
      if (!paired && match) begin
        ev = 1'b1;
      end
      if (ev && !state_reg.ch[i].hold_rd) begin  // [R8] [R13]
        state_next.ch[i].flag = 1'b1;
        state_next.ch[i].armed = 1'b0;  // [R9]
      end

      // Pin drive
      if (!cap_mode && !cmp_mode) begin
        state_next.ch[i].pin = ~state_reg.ch[i].msa;  // [R15]
      end else if (cmp_mode && !paired) begin
        if (wrap) begin
          // Full duty request only lands at a period boundary
          state_next.ch[i].max_act = state_reg.ch[i].max;  // [R21]
        end
        if (wrap && state_reg.ch[i].max_act) begin
          state_next.ch[i].pin = ~state_reg.ch[i].elsa;  // [R21]
        end else if (wrap && state_reg.ch[i].tov) begin  // [R19]
          if (!state_reg.ch[i].hold_rd) begin  // [R20]
            state_next.ch[i].pin = ~state_reg.ch[i].pin;
          end
        end else if (match && !state_reg.ch[i].max_act) begin  // [R16]
          unique case ({state_reg.ch[i].elsb, state_reg.ch[i].elsa})
            2'b01: begin
              if (!state_reg.ch[i].hold_rd) begin  // [R20]
                state_next.ch[i].pin = ~state_reg.ch[i].pin;
              end
            end
            2'b10:   state_next.ch[i].pin = 1'b0;
            2'b11:   state_next.ch[i].pin = 1'b1;
            default: ;
          endcase
        end
      end
    end
    if (wrap) begin
      // Buffered pair swaps to the freshly written half at each period
      state_next.pair_act = state_reg.pair_last;
    end

    if (i_sys_rst) begin
      state_next = '0;
      state_next.halt = `TIM_RST_HALT;  // [R24]
      state_next.modv = `TIM_RST_MOD;  // [R6]
    end
  end

  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    o_rd_data = state_reg.rd_data;
    o_wrap_irq = state_reg.wrap_flag & state_reg.wrap_ie & ~state_reg.mod_pending;  // [R6]
    for (int k = 0; k < 4; k++) begin
      o_channel_pin[k] = state_reg.ch[k].pin;
      o_channel_pin_oe[k] = (state_reg.ch[k].msb || state_reg.ch[k].msa) &&
                            {state_reg.ch[k].elsb, state_reg.ch[k].elsa} != 2'b00 &&
                            !((k % 2 == 1) && state_reg.ch[k - (k % 2)].msb);  // [R16]
      o_channel_irq[k] = state_reg.ch[k].flag & state_reg.ch[k].ie & ~state_reg.dma[k];  // [R11]
      o_channel_dma_req[k] = state_reg.ch[k].flag & state_reg.ch[k].ie & state_reg.dma[k];
    end
  end
endmodule : timer_capture_compare_pwm
`default_nettype wire

//--- common/timer_cfg.svh
// Summary of operation
// [R1] Halt and counter reset written together clear the counter and keep it stopped.
// [R2] Divider select picks bus clock, bus clock over 2 to 64, or external clock.
// [R3] High counter read latches low byte; later high reads keep it until low read.
// [R4] System reset and counter reset bit clear both counter bytes.
// [R5] Counter equal to modulo sets wrap flag; next count clock restarts from zero. Here the flag sets on that restarting count clock.
// [R6] Modulo high write suppresses wrap flag until modulo low write; reset sets modulo.
// [R7] Software should reset the counter before writing modulo bytes.
// [R8] Channel flag sets on active pin edge in capture, on match in compare.
// [R9] Interrupt routing: flag clears by status read with flag then zero write.
// [R10] DMA routing: any access to channel low value byte clears the flag.
// [R11] Request enable gates requests; DMA route picks CPU or DMA request.
// [R12] Software keeps DMA route clear while a channel runs buffered PWM.
// [R13] High value read holds off flag setting until low value read.
// [R14] Buffered mode bit only on channels 0 and 2; disables next channel.
// [R15] Mode bit A picks capture or compare, or initial pin level at 00.
// [R16] Edge/level field picks capture edge or compare pin action; 00 is port.
// [R17] Software sets halt and counter reset before changing channel mode bits.
// [R18] Software keeps the pin stable two bus clocks before enabling capture.
// [R19] Toggle-on-wrap toggles pin at wrap in compare modes and beats compare.
// [R20] High value read blocks pin toggling until low value read.
// [R21] Full duty force acts from the next period and forces 100% duty.
// [R22] High read blocks captures; high write blocks compares until low access.
// [R23] Counter reset bit clears counter and prescaler and always reads zero.
// [R24] Halt bit freezes the counter; reset sets it.
// [R25] Counter, modulo and channel values are 16 bits as two bytes.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define TIM_A_CTL      8'h00
`define TIM_A_CNT_HI   8'h01
`define TIM_A_CNT_LO   8'h02
`define TIM_A_MOD_HI   8'h03
`define TIM_A_MOD_LO   8'h04
`define TIM_A_CH_BASE  8'h05
`define TIM_A_CH_STEP  8'h03
`define TIM_A_DMA      8'h11
`define TIM_B_FLAG     7
`define TIM_B_IE       6
`define TIM_B_HALT     5
`define TIM_B_RST      4
`define TIM_B_MSB      5
`define TIM_B_MSA      4
`define TIM_B_ELSB     3
`define TIM_B_ELSA     2
`define TIM_B_TOV      1
`define TIM_B_MAX      0
`define TIM_RST_MOD    16'hFFFF
`define TIM_RST_HALT   1'b1
`define TIM_PSEL_EXT   3'h7
`endif

//--- common/timer_pkg.sv
package timer_pkg;
  typedef struct packed {
    logic        flag;
    logic        ie;
    logic        msb;
    logic        msa;
    logic        elsb;
    logic        elsa;
    logic        tov;
    logic        max;
    logic [15:0] val;
    logic        armed;
    logic        hold_rd;
    logic        hold_wr;
    logic        pin;
    logic        max_act;
  } channel_t;

  typedef struct packed {
    logic            wrap_flag;
    logic            wrap_ie;
    logic            halt;
    logic [2:0]      psel;
    logic            wrap_armed;
    logic            mod_pending;
    logic [15:0]     cnt;
    logic [15:0]     modv;
    logic [7:0]      lo_latch;
    logic            cnt_latched;
    logic [5:0]      presc;
    logic            ext_s1;
    logic            ext_s2;
    logic            ext_prev;
    logic [3:0]      pin_s1;
    logic [3:0]      pin_s2;
    logic [3:0]      pin_prev;
    logic [3:0]      dma;
    logic [1:0]      pair_last;
    logic [1:0]      pair_act;
    logic [7:0]      rd_data;
    channel_t [3:0]  ch;
  } state_t;
endpackage : timer_pkg

//--- verification/timer_capture_compare_pwm_properties.sv
`timescale 1ns/1ns
`default_nettype none
module timer_checker (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic [3:0] o_channel_pin_oe,
  input wire logic       o_wrap_irq,
  input wire logic [3:0] o_channel_irq,
  input wire logic [3:0] o_channel_dma_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************
  // Helper state
  // ****************
  logic ctl_seen_reg;
  logic mod_seen_reg;
  logic mod_pend_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctl_seen_reg <= 1'b0;
      mod_seen_reg <= 1'b0;
      mod_pend_reg <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 8'h00) ctl_seen_reg <= 1'b1;
      if (i_addr == 8'h03 || i_addr == 8'h04) mod_seen_reg <= 1'b1;
      if (i_addr == 8'h03) mod_pend_reg <= 1'b1;
      if (i_addr == 8'h04) mod_pend_reg <= 1'b0;
    end
  end
  sequence s_halt_rst;
    i_wr && i_addr == 8'h00 && i_wr_data[5:4] == 2'b11;
  endsequence
  sequence s_rd_hi;
    i_rd && i_addr == 8'h01;
  endsequence
  // ****************
  // Properties
  // ****************
  a_ctl_reset_value: assert property (i_rd && i_addr == 8'h00 && !ctl_seen_reg
    |=> o_rd_data == 8'h20) else $error("control reset value wrong");
  a_cnt_reset_zero: assert property ((i_rd && (i_addr == 8'h01 || i_addr == 8'h02))
    && !ctl_seen_reg |=> o_rd_data == 8'h00) else $error("counter not zero after reset");
  a_mod_reset_ones: assert property ((i_rd && (i_addr == 8'h03 || i_addr == 8'h04))
    && !mod_seen_reg |=> o_rd_data == 8'hFF) else $error("modulo not all ones");
  a_rst_bit_zero: assert property (i_rd && i_addr == 8'h00 |=> !o_rd_data[4])
    else $error("counter reset bit read as one");
  a_halt_clears: assert property (s_halt_rst ##2 s_rd_hi |=> o_rd_data == 8'h00)
    else $error("counter not cleared by halt with reset");
  a_wrap_masked: assert property (mod_pend_reg |-> !o_wrap_irq)
    else $error("wrap request during modulo update");
  a_route_exclusive: assert property ((o_channel_irq & o_channel_dma_req) == 4'h0)
    else $error("request on both routes");
  a_flag_write_one: assert property (o_channel_irq[0] && i_wr && i_addr == 8'h05
    && i_wr_data[7:6] == 2'b11 |=> o_channel_irq[0]) else $error("flag lost on write of one");
endmodule : timer_checker
`default_nettype wire

//--- verification/channel_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module channel_far_end (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_level,
  input  wire logic       i_go,
  input  wire logic [3:0] i_count,
  output logic      [3:0] o_pin,
  output logic            o_ext_clk,
  output logic            o_busy
);
  logic [3:0] left_reg = 4'h0;
  logic [2:0] phase_reg = 3'h0;
  initial o_pin = 4'h0;
  initial o_ext_clk = 1'b0;
  initial o_busy = 1'b0;
  // Pulses are four clocks high and low, well under half the bus rate
  always @(posedge i_clk) begin
    o_pin <= i_level;
    if (i_go) begin
      left_reg <= i_count;
      phase_reg <= 3'h0;
      o_busy <= (i_count != 4'h0);
    end else if (o_busy) begin
      o_ext_clk <= ~phase_reg[2];
      phase_reg <= phase_reg + 3'h1;
      if (phase_reg == 3'h7) begin
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) o_busy <= 1'b0;
      end
    end else begin
      o_ext_clk <= 1'b0;
    end
  end
endmodule : channel_far_end
`default_nettype wire

//--- verification/timer_capture_compare_pwm_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module timer_capture_compare_pwm_bench;
  logic i_clk, i_sys_rst, wr_s, rd_s, ext_go, ext_clk, busy, p0;
  logic [7:0] addr, wdata, rd_data;
  logic [3:0] ext_n, far_level, far_pin, pin_out, pin_oe, pin_wire, ch_irq, dma_req;
  logic wrap_irq;
  int bad_count, total_checks, cycles;
  assign pin_wire = (pin_oe & pin_out) | (~pin_oe & far_pin);
  timer_capture_compare_pwm dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
    .i_wr_data(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(rd_data),
    .i_external_count_clock(ext_clk), .i_channel_pin(pin_wire), .o_channel_pin(pin_out),
    .o_channel_pin_oe(pin_oe), .o_wrap_irq(wrap_irq), .o_channel_irq(ch_irq),
    .o_channel_dma_req(dma_req));
  channel_far_end far (.i_clk(i_clk), .i_level(far_level), .i_go(ext_go), .i_count(ext_n),
    .o_pin(far_pin), .o_ext_clk(ext_clk), .o_busy(busy));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", bad_count, total_checks);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // Hang guard: the whole sequence needs well under 3000 clocks
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge i_clk);
    wr_s <= 1'b0;
    // Let the write settle before a caller looks at outputs
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask : rd
  // Waits out the pulses plus the input synchroniser latency
  task automatic pulses(input logic [3:0] n);
    int k;
    @(posedge i_clk);
    ext_n <= n; ext_go <= 1'b1;
    @(posedge i_clk);
    ext_go <= 1'b0;
    #1;
    for (k = 0; k < 300 && busy; k++) @(posedge i_clk);
    repeat (6) @(posedge i_clk);
    #1;
  endtask : pulses
  initial begin
    {wr_s, rd_s, ext_go, addr, wdata, ext_n, far_level} = '0;
    bad_count = 0; total_checks = 0; cycles = 0;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(8'h00, 8'h20);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'hFF);
    rd(8'h04, 8'hFF);
    rd(8'h05, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h00, 8'h07);
    pulses(4'h5);
    rd(8'h01, 8'h00);
    pulses(4'h3);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h05);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h08);
    wr(8'h0B, 8'h44);
    repeat (3) @(posedge i_clk);
    far_level <= 4'h4;
    repeat (10) @(posedge i_clk);
    #1;
    `CHK(ch_irq, 4'h4)
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h08);
    rd(8'h0B, 8'hC4);
    wr(8'h0B, 8'h44);
    `CHK(ch_irq, 4'h0)
    wr(8'h00, 8'h37);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h00, 8'h27);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h03);
    wr(8'h00, 8'h47);
    pulses(4'h3);
    `CHK(wrap_irq, 1'b0)
    pulses(4'h1);
    `CHK(wrap_irq, 1'b1)
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    `CHK(wrap_irq, 1'b0)
    wr(8'h04, 8'h03);
    `CHK(wrap_irq, 1'b1)
    rd(8'h00, 8'hC7);
    wr(8'h00, 8'h47);
    `CHK(wrap_irq, 1'b0)
    wr(8'h00, 8'h37);
    wr(8'h05, 8'h54);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h02);
    p0 = pin_out[0];
    wr(8'h00, 8'h07);
    pulses(4'h2);
    `CHK(ch_irq, 4'h1)
    `CHK(pin_out[0], ~p0)
    `CHK(pin_oe[0], 1'b1)
    wr(8'h05, 8'hD4);
    `CHK(ch_irq, 4'h1)
    wr(8'h05, 8'h54);
    `CHK(ch_irq, 4'h1)
    rd(8'h05, 8'hD4);
    wr(8'h05, 8'h54);
    `CHK(ch_irq, 4'h0)
    wr(8'h11, 8'h01);
    pulses(4'h4);
    `CHK(dma_req, 4'h1)
    `CHK(ch_irq, 4'h0)
    rd(8'h07, 8'h02);
    `CHK(dma_req, 4'h0)
    wr(8'h11, 8'h00);
    rd(8'h06, 8'h00);
    pulses(4'h4);
    `CHK(ch_irq, 4'h0)
    rd(8'h07, 8'h02);
    pulses(4'h4);
    `CHK(ch_irq, 4'h1)
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h40);
    wr(8'h05, 8'h20);
    rd(8'h08, 8'h00);
    wrap_up();
  end
endmodule : timer_capture_compare_pwm_bench
bind timer_capture_compare_pwm timer_checker chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .o_channel_pin_oe(o_channel_pin_oe), .o_wrap_irq(o_wrap_irq),
  .o_channel_irq(o_channel_irq), .o_channel_dma_req(o_channel_dma_req));
`default_nettype wire
